// File: verilog/pusc_pkg.sv
package pusc_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [6:0] PUSC_POWER_DOWN_CONTROL_ADDR = 7'h1e;
	localparam int PUSC_PLL_OFF_BIT = 0;
	localparam int PUSC_RECEIVER_OFF_BIT = 1;
	localparam int PUSC_TRANSMITTER_OFF_BIT = 2;
	localparam int PUSC_OSCILLATOR_OFF_BIT = 3;
	localparam int PUSC_AUDIO_IF_OFF_BIT = 4;
	localparam int PUSC_OUTPUTS_HIZ_BIT = 5;
	localparam logic [7:0] PUSC_PWR_RESET_SW = 8'h07;
	localparam logic [7:0] PUSC_PWR_RESET_HW = 8'h00;
	localparam logic [7:0] PUSC_PWR_WRITE_MASK = 8'h3f;

	// ****************************************************************
	// Strap window timing
	// ****************************************************************
	localparam int PUSC_WIN_MIN_NS = 9400;
	localparam int PUSC_WIN_MAX_NS = 25600;
	localparam int PUSC_XTAL_MAX_HZ = 27000000;
	localparam int PUSC_XTAL_MIN_HZ = 10000000;
	// Window cycles counted in crystal cycles: 9.4us at 27MHz
	localparam longint PUSC_WIN_XTAL_CYCLES = (64'(PUSC_WIN_MIN_NS) * PUSC_XTAL_MAX_HZ + 64'd999999999) / 64'd1000000000;
	localparam int PUSC_CLK_PERIOD_NS = 10;
	localparam int PUSC_SYS_DIV_MAX = 100000000 / PUSC_XTAL_MIN_HZ;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0]
	{
		PUSC_ST_SAMPLE = 2'b00,
		PUSC_ST_WINDOW = 2'b01,
		PUSC_ST_RUN = 2'b10
	} pusc_state_t;

	typedef struct packed
	{
		logic serial_data_in_strap;
		logic serial_clock_strap;
		logic serial_data_out_strap;
		logic chip_select_strap;
		logic general_output_zero;
	} pusc_straps_t;

	typedef struct packed
	{
		logic hardware_control_select;
		logic three_wire_select;
		logic address_select;
		logic audio_if_master_slave;
		logic transmit_source_select;
		logic [1:0] audio_if_format_code;
	} pusc_cfg_t;

	typedef struct packed
	{
		logic transmit_error_flag;
		logic non_audio_flag;
		logic unlock_flag;
		logic general_flag_output;
	} pusc_flags_t;
endpackage

// File: verilog/pusc_power_up_strap_config.sv
`timescale 1ns/1ps
// Function
// - Configuration is taken from the five strap pins at power up and at every hardware reset release.
// - A low serial data in strap picks hardware control, a high one software control.
// - In software control a low general output zero strap picks 2-wire, a high one 3-wire.
// - Strap meaning follows the mode: hardware mode gives master/slave, transmit source and a format code.
// - In hardware control the strapped two-bit code fixes the audio interface format.
// - All strap pins stay inputs for 9.4us to 25.6us after reset release.
// - The input window is counted in crystal reference cycles.
// - At the end of the window each strap pin other than serial data in takes its selected role as flag, general output or serial port pin.
// - Software control starts with PLL, receiver and transmitter powered down; the host clears bits to enable them.
// - Hardware control powers all functions up with no register access.
// - Power-down bits 0..2 disable the PLL, receiver and transmitter, reset value one.
// - Power-down bits 3 and 4 stop the oscillator and audio interface, reset value zero.
// - Power-down bit 5 sets every output to high impedance, reset value zero.
module pusc_power_up_strap_config
	import pusc_pkg::*;
#(
	parameter int WIN_XTAL_CYCLES = int'(PUSC_WIN_XTAL_CYCLES),
	parameter int XTAL_DIV = 4
)
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic xtal_tick,
	input wire pusc_straps_t strap_pin_in,
	output pusc_straps_t strap_pin_out,
	output pusc_straps_t strap_pin_oe,
	input wire logic reg_write,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire pusc_flags_t hw_flags,
	input wire logic [1:0] sw_gpo_data,
	output pusc_cfg_t cfg,
	output logic config_done,
	output logic pll_enable,
	output logic receiver_enable,
	output logic transmitter_enable,
	output logic oscillator_enable,
	output logic audio_if_enable,
	output logic outputs_hiz
);
	initial
	begin
		if (WIN_XTAL_CYCLES < 1 || WIN_XTAL_CYCLES > 65535)
			$error("window length out of range");
		if (XTAL_DIV < 1)
			$error("bad crystal divider");
		if ($bits(pusc_straps_t) != 5)
			$error("strap record must hold five pins");
	end

	// ****************************************************************
	// Strap synchronisers
	// ****************************************************************
	// Straps are board levels with no relation to clk_sys
	pusc_straps_t sync1_r;
	pusc_straps_t sync2_r;
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= strap_pin_in;
			sync2_r <= sync1_r;
		end
	end

	// ****************************************************************
	// Crystal reference
	// ****************************************************************
	// Crystal tick is an enable on clk_sys, not a clock
	logic xtal_sync1_r;
	logic xtal_sync2_r;
	logic xtal_prev_r;
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			xtal_sync1_r <= 1'b0;
			xtal_sync2_r <= 1'b0;
			xtal_prev_r <= 1'b0;
		end
		else
		begin
			xtal_sync1_r <= xtal_tick;
			xtal_sync2_r <= xtal_sync1_r;
			xtal_prev_r <= xtal_sync2_r;
		end
	end
	wire logic xtal_edge = xtal_sync2_r & ~xtal_prev_r;

	// ****************************************************************
	// Window sequencer
	// ****************************************************************
	pusc_state_t state_r;
	pusc_state_t state_nxt;
	logic [15:0] win_cnt_r;
	logic [15:0] win_cnt_nxt;
	pusc_cfg_t cfg_r;
	logic [7:0] pwr_r;
	logic [7:0] pwr_nxt;

	// Sample only after the synchroniser has filled with post-reset pin levels
	logic [1:0] settle_r;
	wire logic settled = (settle_r == 2'd2);
	wire logic win_done = (win_cnt_r == 16'(WIN_XTAL_CYCLES - 1)) && xtal_edge;
	wire logic hw_mode = ~sync2_r.serial_data_in_strap;

	always_comb
	begin
		state_nxt = state_r;
		win_cnt_nxt = win_cnt_r;
		case (state_r)
			PUSC_ST_SAMPLE:
			begin
				if (settled)
					state_nxt = PUSC_ST_WINDOW;
			end
			PUSC_ST_WINDOW:
			begin
				if (win_done)
					state_nxt = PUSC_ST_RUN;
				else if (xtal_edge)
					win_cnt_nxt = win_cnt_r + 16'd1;
			end
			PUSC_ST_RUN:
				state_nxt = PUSC_ST_RUN;
			default:
				state_nxt = PUSC_ST_SAMPLE;
		endcase
	end

	// ****************************************************************
	// Sequencer registers
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			state_r <= PUSC_ST_SAMPLE;
		else
			state_r <= state_nxt;
	end

	// Cleared on every reset so each release gets a full window
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			win_cnt_r <= '0;
		else
			win_cnt_r <= win_cnt_nxt;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			settle_r <= '0;
		else if (!settled)
			settle_r <= settle_r + 2'd1;
	end

	// ****************************************************************
	// Configuration latch
	// ****************************************************************
	wire logic take_straps = (state_r == PUSC_ST_SAMPLE) && settled;
	wire logic strap_clock = sync2_r.serial_clock_strap;
	wire logic strap_dout = sync2_r.serial_data_out_strap;
	wire logic strap_select = sync2_r.chip_select_strap;
	wire logic strap_gpo = sync2_r.general_output_zero;
	pusc_cfg_t cfg_nxt;
	always_comb
	begin
		cfg_nxt.hardware_control_select = hw_mode;
		cfg_nxt.three_wire_select = ~hw_mode & strap_gpo;
		cfg_nxt.address_select = ~hw_mode & ~strap_gpo & strap_select;
		cfg_nxt.audio_if_master_slave = hw_mode & strap_clock;
		cfg_nxt.transmit_source_select = hw_mode & strap_select;
		cfg_nxt.audio_if_format_code = hw_mode ?
			{strap_gpo, strap_dout} : 2'b00;
	end

	// ****************************************************************
	// Power-down register
	// ****************************************************************
	wire logic pwr_sel = reg_write && (reg_addr == PUSC_POWER_DOWN_CONTROL_ADDR);
	// Dropped before run and in hardware control
	wire logic pwr_wr_ok = pwr_sel && (state_r == PUSC_ST_RUN) && !cfg_r.hardware_control_select;
	always_comb
	begin
		pwr_nxt = pwr_r;
		if (take_straps)
			pwr_nxt = hw_mode ? PUSC_PWR_RESET_HW : PUSC_PWR_RESET_SW;
		else if (pwr_wr_ok)
			pwr_nxt = reg_wdata & PUSC_PWR_WRITE_MASK;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			cfg_r <= '0;
		else if (take_straps)
			cfg_r <= cfg_nxt;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			pwr_r <= PUSC_PWR_RESET_SW;
		else
			pwr_r <= pwr_nxt;
	end

	// ****************************************************************
	// Register read and status
	// ****************************************************************
	assign reg_rdata = pwr_r;
	assign cfg = cfg_r;
	assign config_done = (state_r == PUSC_ST_RUN);

	// ****************************************************************
	// Function enables
	// ****************************************************************
	// One enable per off bit; a set bit stops that function
	wire logic [4:0] fn_enable;
	for (genvar i = 0; i < 5; i++)
	begin : g_fn_enable
		assign fn_enable[i] = ~pwr_r[i];
	end
	assign pll_enable = fn_enable[PUSC_PLL_OFF_BIT];
	assign receiver_enable = fn_enable[PUSC_RECEIVER_OFF_BIT];
	assign transmitter_enable = fn_enable[PUSC_TRANSMITTER_OFF_BIT];
	assign oscillator_enable = fn_enable[PUSC_OSCILLATOR_OFF_BIT];
	assign audio_if_enable = fn_enable[PUSC_AUDIO_IF_OFF_BIT];
	assign outputs_hiz = pwr_r[PUSC_OUTPUTS_HIZ_BIT];

	// ****************************************************************
	// Pin roles after the window
	// ****************************************************************
	// Serial-interface pins in software mode belong to the control port, not driven here
	pusc_straps_t out_nxt;
	pusc_straps_t oe_role;
	always_comb
	begin
		out_nxt = '0;
		oe_role = '0;
		if (cfg_r.hardware_control_select)
		begin
			out_nxt.serial_clock_strap = hw_flags.transmit_error_flag;
			out_nxt.serial_data_out_strap = hw_flags.non_audio_flag;
			out_nxt.chip_select_strap = hw_flags.unlock_flag;
			out_nxt.general_output_zero = hw_flags.general_flag_output;
			oe_role = 5'b01111;
		end
		else
		begin
			out_nxt.general_output_zero = sw_gpo_data[0];
			oe_role.general_output_zero = 1'b1;
			if (!cfg_r.three_wire_select)
			begin
				out_nxt.serial_data_out_strap = sw_gpo_data[1];
				out_nxt.chip_select_strap = sw_gpo_data[0];
				oe_role.serial_data_out_strap = 1'b1;
				oe_role.chip_select_strap = 1'b1;
			end
		end
	end

	// Taken from the next state so pins switch in the cycle config_done rises
	wire pusc_straps_t oe_nxt = (state_nxt == PUSC_ST_RUN && !pwr_nxt[PUSC_OUTPUTS_HIZ_BIT]) ?
		oe_role : '0;

	// ****************************************************************
	// Pin drive registers
	// ****************************************************************
	pusc_straps_t out_r;
	pusc_straps_t oe_r;
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			out_r <= '0;
		else
			out_r <= out_nxt;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			oe_r <= '0;
		else
			oe_r <= oe_nxt;
	end
	assign strap_pin_out = out_r;
	assign strap_pin_oe = oe_r;
endmodule

// File: test/pusc_checker.sv
`timescale 1ns/1ps
module pusc_checker
	import pusc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire pusc_straps_t strap_pin_oe,
	input wire logic reg_write,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire pusc_cfg_t cfg,
	input wire logic config_done,
	input wire logic pll_enable,
	input wire logic receiver_enable,
	input wire logic transmitter_enable,
	input wire logic oscillator_enable,
	input wire logic audio_if_enable,
	input wire logic outputs_hiz
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	property p_win_in; !config_done |-> strap_pin_oe == 5'h00; endproperty
	a_win_in: assert property (p_win_in) else $error("pin driven inside window");
	property p_en; {audio_if_enable, oscillator_enable, transmitter_enable, receiver_enable, pll_enable}
		== ~reg_rdata[4:0]; endproperty
	a_en: assert property (p_en) else $error("enables differ from register");
	property p_hiz; outputs_hiz |-> reg_rdata[5] && strap_pin_oe == 5'h00; endproperty
	a_hiz: assert property (p_hiz) else $error("hiz bit not obeyed");
	property p_hw_pwr; config_done && cfg.hardware_control_select |-> reg_rdata == 8'h00; endproperty
	a_hw_pwr: assert property (p_hw_pwr) else $error("hw mode not powered up");
	property p_wr; config_done && !cfg.hardware_control_select && reg_write && reg_addr == PUSC_POWER_DOWN_CONTROL_ADDR
		|=> reg_rdata == ($past(reg_wdata) & PUSC_PWR_WRITE_MASK); endproperty
	a_wr: assert property (p_wr) else $error("write not stored");
	property p_oe_hw; config_done && cfg.hardware_control_select && !outputs_hiz |-> strap_pin_oe == 5'h0f; endproperty
	a_oe_hw: assert property (p_oe_hw) else $error("hw pin roles wrong");
	property p_oe_sw; config_done && !cfg.hardware_control_select && !outputs_hiz
		|-> strap_pin_oe == (cfg.three_wire_select ? 5'h01 : 5'h07); endproperty
	a_oe_sw: assert property (p_oe_sw) else $error("sw pin roles wrong");
	property p_done; config_done |=> $stable(cfg) && config_done; endproperty
	a_done: assert property (p_done) else $error("config changed after window");
endmodule

// File: test/pusc_board_model.sv
`timescale 1ns/1ps
module pusc_board_model
	import pusc_pkg::*;
(
	input wire pusc_straps_t straps,
	input wire pusc_straps_t pin_out,
	input wire pusc_straps_t pin_oe,
	output pusc_straps_t pin_in,
	output logic xtal_tick
);
	// Strap resistors pull every released pin to its strap level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & straps);
	// Free running crystal, 25MHz, phase unrelated to clk_sys
	initial
	begin
		xtal_tick = 1'b0;
		#7;
		forever #20 xtal_tick = ~xtal_tick;
	end
endmodule

// File: test/power_up_strap_config_bench.sv
`timescale 1ns/1ps
module power_up_strap_config_bench
	import pusc_pkg::*;
;
	logic clk_sys, rst_b, xtal_tick, reg_write, config_done, outputs_hiz;
	logic pll_enable, receiver_enable, transmitter_enable, oscillator_enable, audio_if_enable;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [1:0] sw_gpo_data;
	pusc_straps_t straps, pin_in, pin_out, pin_oe;
	pusc_flags_t hw_flags;
	pusc_cfg_t cfg;
	int num_errors = 0, n_checks = 0, cycles = 0;
	pusc_power_up_strap_config #(.WIN_XTAL_CYCLES(4)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .xtal_tick(xtal_tick),
		.strap_pin_in(pin_in), .strap_pin_out(pin_out), .strap_pin_oe(pin_oe), .reg_write(reg_write),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .hw_flags(hw_flags),
		.sw_gpo_data(sw_gpo_data), .cfg(cfg), .config_done(config_done), .pll_enable(pll_enable),
		.receiver_enable(receiver_enable), .transmitter_enable(transmitter_enable),
		.oscillator_enable(oscillator_enable), .audio_if_enable(audio_if_enable), .outputs_hiz(outputs_hiz));
	pusc_board_model u_board (.straps(straps), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
		.xtal_tick(xtal_tick));
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Runaway guard, the whole run needs about 100 cycles
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			num_errors++;
			give_verdict;
		end
	end
	task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task wr(input logic [6:0] a, input logic [7:0] d);
		reg_write = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_write = 1'b0;
		@(negedge clk_sys);
	endtask
	task boot(input pusc_straps_t s);
		int n;
		straps = s;
		rst_b = 1'b0;
		repeat (5) @(negedge clk_sys);
		chk("pwr_in_reset", 8'h07, reg_rdata);
		rst_b = 1'b1;
		n = 0;
		while (config_done !== 1'b1 && n < 100)
		begin
			chk("oe_in_window", 8'h00, pin_oe);
			@(negedge clk_sys);
			n++;
		end
		chk("window_len", 8'h01, 8'(n >= 12 && n <= 30));
	endtask
	initial
	begin
		rst_b = 1'b0;
		reg_write = 1'b0;
		reg_addr = 7'h00;
		reg_wdata = 8'h00;
		sw_gpo_data = 2'h0;
		hw_flags = 4'h0;
		straps = 5'h0b;
		boot(5'h0b);
		chk("hw_mode", 8'h01, cfg.hardware_control_select);
		chk("ms_tx", 8'h03, {cfg.audio_if_master_slave, cfg.transmit_source_select});
		chk("format", 8'h02, cfg.audio_if_format_code);
		wr(PUSC_POWER_DOWN_CONTROL_ADDR, 8'hff);
		chk("hw_pwr", 8'h00, reg_rdata);
		hw_flags = 4'ha;
		repeat (6) @(negedge clk_sys);
		chk("hw_flags_out", 8'h0a, pin_out[3:0]);
		$display("test hardware mode done");
		boot(5'h12);
		chk("sw2_mode", 8'h01, {cfg.hardware_control_select, cfg.three_wire_select, cfg.address_select});
		chk("sw_pwr", 8'h07, reg_rdata);
		sw_gpo_data = 2'h1;
		repeat (6) @(negedge clk_sys);
		chk("sw_gpo_out", 8'h03, pin_out[2:0]);
		wr(7'h1d, 8'h00);
		chk("unmapped", 8'h07, reg_rdata);
		wr(PUSC_POWER_DOWN_CONTROL_ADDR, 8'hff);
		wr(PUSC_POWER_DOWN_CONTROL_ADDR, 8'h1a);
		chk("pwr_wr", 8'h1a, reg_rdata);
		chk("enables", 8'h05, {audio_if_enable, oscillator_enable, transmitter_enable, receiver_enable,
			pll_enable});
		wr(PUSC_POWER_DOWN_CONTROL_ADDR, 8'h20);
		chk("hiz_oe", 8'h00, pin_oe);
		wr(PUSC_POWER_DOWN_CONTROL_ADDR, 8'h00);
		chk("sw2_oe", 8'h07, pin_oe);
		$display("test software 2-wire done");
		boot(5'h15);
		chk("sw3_mode", 8'h01, cfg.three_wire_select);
		chk("sw3_oe", 8'h01, pin_oe);
		chk("pwr_restored", 8'h07, reg_rdata);
		$display("test software 3-wire done");
		give_verdict;
	end
endmodule
bind pusc_power_up_strap_config pusc_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .strap_pin_oe(strap_pin_oe),
	.reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cfg(cfg),
	.config_done(config_done), .pll_enable(pll_enable), .receiver_enable(receiver_enable),
	.transmitter_enable(transmitter_enable), .oscillator_enable(oscillator_enable),
	.audio_if_enable(audio_if_enable), .outputs_hiz(outputs_hiz));
